// [core/nvm_data_access.sv]
// Purpose: register front end and storage of the nonvolatile data store
// Assumes: special function register bus on the system clock, one access per cycle
// Notes:   reads answer one cycle after sfr_rd_in; storage is flip-flops
// How it works
// - store holds 2048 bytes, addressed by high bits 2..0 above low byte
// - store is off the memory map; every access moves one byte via registers
// - address and data registers sit in sector 0, reached directly
// - control register answers only indirect access at sector 1, location 40H
// - low address register is 8-bit read/write, zero after reset
// - high address keeps bits 2..0; bits 7..3 read zero
// - control bits: timing, wipe enable/go, mode, program enable/go, fetch enable/go
// - data register is 8-bit read/write, zero after reset, carries the byte
// - timing select picks 3.2/2.2 ms or 3.7/3.0 ms erase/write durations
// - wipe go needs wipe enable set first; both clear when erase ends
`timescale 1ns/1ps
`default_nettype none
module nvm_data_access #(
	parameter logic [nvm_pkg::CYC_W-1:0] ERASE_T0_CYC = nvm_pkg::CYC_W'(nvm_pkg::ERASE_T0_CYC),
	parameter logic [nvm_pkg::CYC_W-1:0] WRITE_T0_CYC = nvm_pkg::CYC_W'(nvm_pkg::WRITE_T0_CYC),
	parameter logic [nvm_pkg::CYC_W-1:0] ERASE_T1_CYC = nvm_pkg::CYC_W'(nvm_pkg::ERASE_T1_CYC),
	parameter logic [nvm_pkg::CYC_W-1:0] WRITE_T1_CYC = nvm_pkg::CYC_W'(nvm_pkg::WRITE_T1_CYC)
) (
	input  wire logic       clk_sys_in,
	input  wire logic       srst_in,
	input  wire logic       sfr_sector_in,
	input  wire logic       sfr_indirect_in,
	input  wire logic [7:0] sfr_addr_in,
	input  wire logic       sfr_wr_in,
	input  wire logic       sfr_rd_in,
	input  wire logic [7:0] sfr_wdata_in,
	output var  logic [7:0] sfr_rdata_out,
	output var  logic       nvm_busy_out
);
	nvm_pkg::nvm_state_t state_q, state_d;
	logic [7:0]  addr_low_q, addr_low_d;
	logic [2:0]  addr_high_q, addr_high_d;
	logic [7:0]  data_q, data_d;
	logic [7:0]  ctrl_q, ctrl_d;
	logic [7:0]  rdata_q, rdata_d;
	logic        busy_q, busy_d;
	logic [7:0]  mem_q [nvm_pkg::DEPTH];
	logic        mem_we;
	logic [7:0]  mem_wdata;
	logic        tmr_load;
	logic [nvm_pkg::CYC_W-1:0] tmr_count;
	logic        tmr_done;
	logic [nvm_pkg::ADDR_W-1:0] idx;
	logic        hit_low, hit_high, hit_data, hit_ctrl;

	assign idx      = {addr_high_q, addr_low_q};
	assign hit_low  = (sfr_sector_in == nvm_pkg::SECTOR0) && (sfr_addr_in == nvm_pkg::ADDR_LOW_OFS);
	assign hit_high = (sfr_sector_in == nvm_pkg::SECTOR0) && (sfr_addr_in == nvm_pkg::ADDR_HIGH_OFS);
	assign hit_data = (sfr_sector_in == nvm_pkg::SECTOR0) && (sfr_addr_in == nvm_pkg::DATA_OFS);
	// a direct access to 40H in sector 1 reaches nothing here
	assign hit_ctrl = sfr_indirect_in && (sfr_sector_in == nvm_pkg::SECTOR1)
		&& (sfr_addr_in == nvm_pkg::CTRL_OFS);

	nvm_op_timer u_timer (
		.clk_sys_in (clk_sys_in),
		.srst_in    (srst_in),
		.load_in    (tmr_load),
		.count_in   (tmr_count),
		.done_out   (tmr_done)
	);

	always_comb begin
		state_d     = state_q;
		addr_low_d  = addr_low_q;
		addr_high_d = addr_high_q;
		data_d      = data_q;
		ctrl_d      = ctrl_q;
		busy_d      = busy_q;
		rdata_d     = 8'h00;
		mem_we      = 1'b0;
		mem_wdata   = 8'h00;
		tmr_load    = 1'b0;
		tmr_count   = '0;
		if (sfr_rd_in) begin
			if (hit_low) begin
				rdata_d = addr_low_q;
			end else if (hit_high) begin
				rdata_d = {5'h00, addr_high_q};
			end else if (hit_data) begin
				rdata_d = data_q;
			end else if (hit_ctrl) begin
				rdata_d = ctrl_q;
			end
		end
		unique case (state_q)
			nvm_pkg::ST_IDLE: begin
				// writes are frozen while busy so a running cycle keeps its address and byte
				if (sfr_wr_in && hit_low) begin
					addr_low_d = sfr_wdata_in;
				end
				if (sfr_wr_in && hit_high) begin
					addr_high_d = sfr_wdata_in[2:0];
				end
				if (sfr_wr_in && hit_data) begin
					data_d = sfr_wdata_in;
				end
				if (sfr_wr_in && hit_ctrl) begin
					ctrl_d = sfr_wdata_in;
					// a go bit only sticks when its enable was already set
					ctrl_d[nvm_pkg::WIPE_GO_BIT] = sfr_wdata_in[nvm_pkg::WIPE_GO_BIT]
						& sfr_wdata_in[nvm_pkg::WIPE_EN_BIT] & ctrl_q[nvm_pkg::WIPE_EN_BIT];
					ctrl_d[nvm_pkg::PROG_GO_BIT] = sfr_wdata_in[nvm_pkg::PROG_GO_BIT]
						& sfr_wdata_in[nvm_pkg::PROG_EN_BIT] & ctrl_q[nvm_pkg::PROG_EN_BIT];
					ctrl_d[nvm_pkg::FETCH_GO_BIT] = sfr_wdata_in[nvm_pkg::FETCH_GO_BIT]
						& sfr_wdata_in[nvm_pkg::FETCH_EN_BIT] & ctrl_q[nvm_pkg::FETCH_EN_BIT];
				end else if (ctrl_q[nvm_pkg::WIPE_GO_BIT]) begin
					tmr_load  = 1'b1;
					tmr_count = ctrl_q[nvm_pkg::TIMING_SEL_BIT] ? ERASE_T1_CYC : ERASE_T0_CYC;
					state_d   = nvm_pkg::ST_ERASE;
					busy_d    = 1'b1;
				end else if (ctrl_q[nvm_pkg::PROG_GO_BIT]) begin
					tmr_load  = 1'b1;
					tmr_count = ctrl_q[nvm_pkg::TIMING_SEL_BIT] ? WRITE_T1_CYC : WRITE_T0_CYC;
					state_d   = nvm_pkg::ST_WRITE;
					busy_d    = 1'b1;
				end else if (ctrl_q[nvm_pkg::FETCH_GO_BIT]) begin
					data_d = mem_q[idx];
					ctrl_d[nvm_pkg::FETCH_GO_BIT] = 1'b0;
				end
			end
			nvm_pkg::ST_ERASE: begin
				if (tmr_done) begin
					mem_we    = 1'b1;
					mem_wdata = nvm_pkg::ERASED_BYTE;
					ctrl_d[nvm_pkg::WIPE_EN_BIT] = 1'b0;
					ctrl_d[nvm_pkg::WIPE_GO_BIT] = 1'b0;
					state_d   = nvm_pkg::ST_IDLE;
					busy_d    = 1'b0;
				end
			end
			nvm_pkg::ST_WRITE: begin
				if (tmr_done) begin
					mem_we    = 1'b1;
					mem_wdata = data_q;
					ctrl_d[nvm_pkg::PROG_EN_BIT] = 1'b0;
					ctrl_d[nvm_pkg::PROG_GO_BIT] = 1'b0;
					state_d   = nvm_pkg::ST_IDLE;
					busy_d    = 1'b0;
				end
			end
			default: begin
				state_d = nvm_pkg::ST_IDLE;
				busy_d  = 1'b0;
			end
		endcase
	end

	always_ff @(posedge clk_sys_in) begin
		if (srst_in) begin
			state_q     <= nvm_pkg::ST_IDLE;
			addr_low_q  <= nvm_pkg::REG_RESET;
			addr_high_q <= nvm_pkg::HIGH_RESET;
			data_q      <= nvm_pkg::REG_RESET;
			ctrl_q      <= nvm_pkg::REG_RESET;
			rdata_q     <= nvm_pkg::REG_RESET;
			busy_q      <= 1'b0;
		end else begin
			state_q     <= state_d;
			addr_low_q  <= addr_low_d;
			addr_high_q <= addr_high_d;
			data_q      <= data_d;
			ctrl_q      <= ctrl_d;
			rdata_q     <= rdata_d;
			busy_q      <= busy_d;
		end
	end

	// storage keeps its contents across reset, like the real array
	always_ff @(posedge clk_sys_in) begin
		if (mem_we) begin
			mem_q[idx] <= mem_wdata;
		end
	end

	assign sfr_rdata_out = rdata_q;
	assign nvm_busy_out  = busy_q;

	// helper: length of the current busy period and the length it should have
	logic [nvm_pkg::CYC_W-1:0] run_len_q;
	logic [nvm_pkg::CYC_W-1:0] exp_len_q;
	always_ff @(posedge clk_sys_in) begin
		if (srst_in || tmr_load) begin
			run_len_q <= '0;
			exp_len_q <= srst_in ? '0 : tmr_count;
		end else if (busy_q) begin
			run_len_q <= run_len_q + 1'b1;
		end
	end

	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (srst_in);

	property p_low_reset;
		$fell(srst_in) |-> addr_low_q == 8'h00 && data_q == 8'h00 && addr_high_q == 3'h0;
	endproperty
	a_low_reset: assert property (p_low_reset) else $error("address or data not zero after reset");

	property p_high_zero;
		sfr_rd_in && hit_high |=> sfr_rdata_out[7:3] == 5'h00 && sfr_rdata_out[2:0] == $past(addr_high_q);
	endproperty
	a_high_zero: assert property (p_high_zero) else $error("high address readback wrong");

	property p_direct_ctrl_blocked;
		sfr_wr_in && !sfr_indirect_in && sfr_sector_in && sfr_addr_in == 8'h40 && !tmr_load
			&& state_q == nvm_pkg::ST_IDLE && ctrl_q[2:0] == 3'h0 && !ctrl_q[5] |=> $stable(ctrl_q);
	endproperty
	a_direct_ctrl_blocked: assert property (p_direct_ctrl_blocked) else $error("direct write reached control");

	property p_wipe_needs_enable;
		sfr_wr_in && hit_ctrl && !ctrl_q[6] && state_q == nvm_pkg::ST_IDLE |=> !ctrl_q[5];
	endproperty
	a_wipe_needs_enable: assert property (p_wipe_needs_enable) else $error("erase go set without enable");

	property p_erase_end_clears;
		state_q == nvm_pkg::ST_ERASE && tmr_done |=> !ctrl_q[6] && !ctrl_q[5] && !nvm_busy_out
			&& mem_q[$past(idx)] == 8'hFF;
	endproperty
	a_erase_end_clears: assert property (p_erase_end_clears) else $error("erase end did not clear");

	property p_cycle_length;
		$fell(busy_q) |-> run_len_q == exp_len_q;
	endproperty
	a_cycle_length: assert property (p_cycle_length) else $error("busy period length wrong");

	// measured erase length against the selected time, independent of the timer load path
	property p_erase_len_sel;
		$fell(busy_q) && $past(state_q) == nvm_pkg::ST_ERASE |->
			run_len_q == (ctrl_q[7] ? ERASE_T1_CYC : ERASE_T0_CYC);
	endproperty
	a_erase_len_sel: assert property (p_erase_len_sel) else $error("erase time select wrong");

	property p_fetch_byte;
		state_q == nvm_pkg::ST_IDLE && ctrl_q[0] && !ctrl_q[5] && !ctrl_q[2] && !(sfr_wr_in && hit_ctrl)
			|=> data_q == $past(mem_q[idx]) && !ctrl_q[0];
	endproperty
	a_fetch_byte: assert property (p_fetch_byte) else $error("read did not load data register");

	property p_data_write;
		sfr_wr_in && hit_data && state_q == nvm_pkg::ST_IDLE && !ctrl_q[0] |=> data_q == $past(sfr_wdata_in);
	endproperty
	a_data_write: assert property (p_data_write) else $error("data register write lost");

	property p_ctrl_read;
		sfr_rd_in && hit_ctrl |=> sfr_rdata_out == $past(ctrl_q);
	endproperty
	a_ctrl_read: assert property (p_ctrl_read) else $error("control readback wrong");

	c_erase: cover property (state_q == nvm_pkg::ST_ERASE && tmr_done);
	c_write: cover property (state_q == nvm_pkg::ST_WRITE && tmr_done);
	c_fetch: cover property (state_q == nvm_pkg::ST_IDLE && ctrl_q[0] ##1 !ctrl_q[0]);
endmodule : nvm_data_access
`default_nettype wire

// [core/nvm_op_timer.sv]
// Purpose: down counter that times one erase or write cycle
// Assumes: count_in is at least 1 when load_in pulses
// Notes:   done_out pulses in the last cycle of a count of count_in cycles
`timescale 1ns/1ps
`default_nettype none
module nvm_op_timer (
	input  wire logic                      clk_sys_in,
	input  wire logic                      srst_in,
	input  wire logic                      load_in,
	input  wire logic [nvm_pkg::CYC_W-1:0] count_in,
	output var  logic                      done_out
);
	logic [nvm_pkg::CYC_W-1:0] cnt_q;
	logic [nvm_pkg::CYC_W-1:0] cnt_d;

	always_comb begin
		cnt_d = cnt_q;
		if (load_in) begin
			cnt_d = count_in;
		end else if (cnt_q != '0) begin
			cnt_d = cnt_q - 1'b1;
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (srst_in) begin
			cnt_q <= '0;
		end else begin
			cnt_q <= cnt_d;
		end
	end

	assign done_out = (cnt_q == nvm_pkg::CYC_W'(1)) && !load_in;
endmodule : nvm_op_timer
`default_nettype wire

// [core/nvm_pkg.sv]
// Purpose: shared constants for the nonvolatile data store register front end
// Assumes: 25 MHz system clock, 8-bit special function register bus
// Notes:   times are kept in microseconds, cycle counts derive from them
package nvm_pkg;
	localparam int          CLK_MHZ        = 25;
	localparam int          ADDR_W         = 11;
	localparam int          DEPTH          = 2048;
	localparam int          CYC_W          = 17;
	// sector 0 offsets are chosen, the control offset is fixed
	localparam logic        SECTOR0        = 1'b0;
	localparam logic        SECTOR1        = 1'b1;
	localparam logic [7:0]  ADDR_LOW_OFS   = 8'h2A;
	localparam logic [7:0]  ADDR_HIGH_OFS  = 8'h2B;
	localparam logic [7:0]  DATA_OFS       = 8'h2C;
	localparam logic [7:0]  CTRL_OFS       = 8'h40;
	// control bit positions
	localparam int          TIMING_SEL_BIT = 7;
	localparam int          WIPE_EN_BIT    = 6;
	localparam int          WIPE_GO_BIT    = 5;
	localparam int          MODE_BIT       = 4;
	localparam int          PROG_EN_BIT    = 3;
	localparam int          PROG_GO_BIT    = 2;
	localparam int          FETCH_EN_BIT   = 1;
	localparam int          FETCH_GO_BIT   = 0;
	localparam logic [7:0]  REG_RESET      = 8'h00;
	localparam logic [2:0]  HIGH_RESET     = 3'h0;
	localparam logic [7:0]  ERASED_BYTE    = 8'hFF;
	// cycle durations in microseconds
	localparam int          ERASE_T0_US    = 3200;
	localparam int          WRITE_T0_US    = 2200;
	localparam int          ERASE_T1_US    = 3700;
	localparam int          WRITE_T1_US    = 3000;
	localparam int          ERASE_T0_CYC   = ERASE_T0_US * CLK_MHZ;
	localparam int          WRITE_T0_CYC   = WRITE_T0_US * CLK_MHZ;
	localparam int          ERASE_T1_CYC   = ERASE_T1_US * CLK_MHZ;
	localparam int          WRITE_T1_CYC   = WRITE_T1_US * CLK_MHZ;
	typedef enum logic [1:0] {ST_IDLE, ST_ERASE, ST_WRITE} nvm_state_t;
endpackage : nvm_pkg

// [test/nvm_data_access_bench.sv]
// Purpose: self-checking bench for the nonvolatile data store register front end
// Assumes: small cycle counts for erase and write so that the run stays short
// Notes:   every wait is bounded; a wait that runs out counts as a mismatch
`timescale 1ns/1ps
`default_nettype none
module nvm_data_access_bench;
	localparam logic [7:0] LO = nvm_pkg::ADDR_LOW_OFS;
	localparam logic [7:0] HI = nvm_pkg::ADDR_HIGH_OFS;
	localparam logic [7:0] DT = nvm_pkg::DATA_OFS;
	localparam logic [7:0] CT = nvm_pkg::CTRL_OFS;
	logic       clk_sys_in      = 1'b0;
	logic       srst_in         = 1'b1;
	logic       sfr_sector_in   = 1'b0;
	logic       sfr_indirect_in = 1'b0;
	logic [7:0] sfr_addr_in     = 8'h00;
	logic       sfr_wr_in       = 1'b0;
	logic       sfr_rd_in       = 1'b0;
	logic [7:0] sfr_wdata_in    = 8'h00;
	logic [7:0] sfr_rdata_out;
	logic       nvm_busy_out;
	logic [7:0] v;
	int         fail_count      = 0;
	int         total_checks    = 0;

	always #20 clk_sys_in = ~clk_sys_in;

	nvm_data_access #(
		.ERASE_T0_CYC (17'h0_0014),
		.WRITE_T0_CYC (17'h0_000F),
		.ERASE_T1_CYC (17'h0_0019),
		.WRITE_T1_CYC (17'h0_0012)
	) dut (
		.clk_sys_in      (clk_sys_in),
		.srst_in         (srst_in),
		.sfr_sector_in   (sfr_sector_in),
		.sfr_indirect_in (sfr_indirect_in),
		.sfr_addr_in     (sfr_addr_in),
		.sfr_wr_in       (sfr_wr_in),
		.sfr_rd_in       (sfr_rd_in),
		.sfr_wdata_in    (sfr_wdata_in),
		.sfr_rdata_out   (sfr_rdata_out),
		.nvm_busy_out    (nvm_busy_out)
	);

	task end_of_test;
		$display("checks %0d errors %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : end_of_test

	task check(input logic [16:0] seen, input logic [16:0] exp);
		total_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("ERROR %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task wr(input logic s, input logic i, input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys_in);
		sfr_sector_in   <= s;
		sfr_indirect_in <= i;
		sfr_addr_in     <= a;
		sfr_wdata_in    <= d;
		sfr_wr_in       <= 1'b1;
		@(posedge clk_sys_in);
		sfr_wr_in       <= 1'b0;
	endtask : wr

	// read data is registered, so it is sampled just after the edge that follows the strobe
	task rd(input logic s, input logic i, input logic [7:0] a, output logic [7:0] d);
		@(posedge clk_sys_in);
		sfr_sector_in   <= s;
		sfr_indirect_in <= i;
		sfr_addr_in     <= a;
		sfr_rd_in       <= 1'b1;
		@(posedge clk_sys_in);
		sfr_rd_in       <= 1'b0;
		#1 d = sfr_rdata_out;
	endtask : rd

	task ctl(input logic [7:0] d);
		wr(1'b1, 1'b1, CT, d);
	endtask : ctl

	task expect_ctl(input logic [7:0] exp);
		rd(1'b1, 1'b1, CT, v);
		check(v, exp);
	endtask : expect_ctl

	task set_addr(input logic [7:0] h, input logic [7:0] l);
		wr(1'b0, 1'b0, HI, h);
		wr(1'b0, 1'b0, LO, l);
	endtask : set_addr

	// busy length is counted in cycles seen high, which must equal the chosen count
	task run_op(input logic [7:0] en, input logic [7:0] go, input logic [16:0] len);
		logic [16:0] n;
		n = 17'h0_0000;
		ctl(en);
		ctl(go);
		#1;
		for (int i = 0; i < 10 && nvm_busy_out !== 1'b1; i++) begin
			@(posedge clk_sys_in);
			#1;
		end
		if (nvm_busy_out !== 1'b1) begin
			fail_count++;
			$display("ERROR %0t: operation never started", $time);
			end_of_test();
		end
		while (nvm_busy_out === 1'b1 && n < 17'h0_012C) begin
			n++;
			@(posedge clk_sys_in);
			#1;
		end
		if (nvm_busy_out === 1'b1) begin
			fail_count++;
			$display("ERROR %0t: operation never ended", $time);
			end_of_test();
		end
		check(n, len);
	endtask : run_op

	task fetch(input logic [7:0] h, input logic [7:0] l, input logic [7:0] exp);
		set_addr(h, l);
		ctl(8'h02);
		ctl(8'h03);
		rd(1'b0, 1'b0, DT, v);
		check(v, exp);
	endtask : fetch

	initial begin
		repeat (20) @(posedge clk_sys_in);
		srst_in <= 1'b0;
		rd(1'b0, 1'b0, LO, v);
		check(v, 8'h00);
		rd(1'b0, 1'b0, HI, v);
		check(v, 8'h00);
		rd(1'b0, 1'b0, DT, v);
		check(v, 8'h00);
		expect_ctl(8'h00);
		wr(1'b0, 1'b0, LO, 8'hA5);
		rd(1'b0, 1'b0, LO, v);
		check(v, 8'hA5);
		wr(1'b0, 1'b0, HI, 8'hFF);
		rd(1'b0, 1'b0, HI, v);
		check(v, 8'h07);
		// read data stands one cycle only, then falls back to zero
		@(posedge clk_sys_in);
		#1;
		check(sfr_rdata_out, 8'h00);
		wr(1'b0, 1'b0, DT, 8'h3C);
		rd(1'b0, 1'b0, DT, v);
		check(v, 8'h3C);
		// direct access to the control location must not reach it
		wr(1'b1, 1'b0, CT, 8'h80);
		rd(1'b1, 1'b0, CT, v);
		check(v, 8'h00);
		expect_ctl(8'h00);
		rd(1'b0, 1'b0, 8'h30, v);
		check(v, 8'h00);
		// go bits without a prior enable stay clear, the rest is stored
		ctl(8'hFF);
		expect_ctl(8'hDA);
		ctl(8'h00);
		set_addr(8'h05, 8'hA3);
		run_op(8'h08, 8'h0C, 17'h0_000F);
		expect_ctl(8'h00);
		set_addr(8'h00, 8'hA3);
		wr(1'b0, 1'b0, DT, 8'h11);
		run_op(8'h88, 8'h8C, 17'h0_0012);
		expect_ctl(8'h80);
		fetch(8'h05, 8'hA3, 8'h3C);
		fetch(8'h00, 8'hA3, 8'h11);
		set_addr(8'h05, 8'hA3);
		run_op(8'h40, 8'h60, 17'h0_0014);
		expect_ctl(8'h00);
		fetch(8'h05, 8'hA3, 8'hFF);
		set_addr(8'h00, 8'hA3);
		run_op(8'hC0, 8'hE0, 17'h0_0019);
		expect_ctl(8'h80);
		fetch(8'h00, 8'hA3, 8'hFF);
		// reads still answer while a write cycle runs
		set_addr(8'h02, 8'h10);
		wr(1'b0, 1'b0, DT, 8'h6B);
		ctl(8'h08);
		ctl(8'h0C);
		rd(1'b0, 1'b0, LO, v);
		check(v, 8'h10);
		check(nvm_busy_out, 1'b1);
		for (int i = 0; i < 300 && nvm_busy_out === 1'b1; i++) begin
			@(posedge clk_sys_in);
			#1;
		end
		if (nvm_busy_out !== 1'b0) begin
			fail_count++;
			$display("ERROR %0t: operation never ended", $time);
			end_of_test();
		end
		fetch(8'h02, 8'h10, 8'h6B);
		// a reset in the middle of an erase aborts it and leaves the stored byte
		ctl(8'h40);
		ctl(8'h60);
		repeat (2) @(posedge clk_sys_in);
		#1;
		check(nvm_busy_out, 1'b1);
		@(posedge clk_sys_in);
		srst_in <= 1'b1;
		repeat (2) @(posedge clk_sys_in);
		srst_in <= 1'b0;
		#1;
		check(nvm_busy_out, 1'b0);
		check(sfr_rdata_out, 8'h00);
		rd(1'b0, 1'b0, LO, v);
		check(v, 8'h00);
		expect_ctl(8'h00);
		fetch(8'h02, 8'h10, 8'h6B);
		end_of_test();
	end
endmodule : nvm_data_access_bench
`default_nettype wire
